// File: core/dtw_pkg.sv
// Package of constants and types for the tuning write port
package dtw_pkg;
    localparam int DATA_W = 16;
    localparam int SEL_W = 3;
    localparam int FREQ_W = 32;
    localparam int PHASE_W = 12;
    localparam int N_FREQ = 2;
    localparam int N_PHASE = 4;
    localparam int ACC_W = 32;
    localparam int LUT_W = 12;
    // Register select codes
    localparam logic [2:0] SEL_FREQ0_LO = 3'h0;
    localparam logic [2:0] SEL_FREQ0_HI = 3'h1;
    localparam logic [2:0] SEL_FREQ1_LO = 3'h2;
    localparam logic [2:0] SEL_FREQ1_HI = 3'h3;
    localparam logic [2:0] SEL_PHASE0 = 3'h4;
    // Field positions
    localparam int PHASE_MSB = 11;
    localparam int LO_HALF_LSB = 0;
    localparam int HI_HALF_LSB = 16;
    localparam int LUT_LSB = 20;
    // Reset values
    localparam logic [31:0] FREQ_RST = 32'h0000_0000;
    localparam logic [11:0] PHASE_RST = 12'h000;
    localparam logic [31:0] ACC_RST = 32'h0000_0000;
    localparam logic [11:0] ADDR_RST = 12'h000;

    typedef struct packed {
        logic [2:0] sel;
        logic [15:0] data;
    } dtw_write_s;
endpackage : dtw_pkg

// File: core/dtw_tuning_port.sv
// Tuning register write port and phase accumulator of the oscillator
// Overview of operation
// - Data and register select are captured at the first clock rising edge after the write strobe rises.
// - Captured word moves into its destination on a later clock edge.
// - Destination updates on the second clock edge following the strobe rise.
// - Select 0-3 hit frequency word halves, 4-7 hit phase offsets 0-3.
// - Two 32-bit frequency words; tuning_word_sel chooses between them.
// - Phase offsets take data bits 11:0; upper bits ignored.
// - Offset select bits pick one of four phase offsets.
// - Selected offset is added to accumulator output to form table address.
// - Offset select bits are sampled every clock rising edge.
// - Sleep low halts the accumulator and disables the output stage.
// - Accumulator reset low forces the phase accumulator to zero.
// - tuning_word_sel is sampled every clock rising edge.
// - 32-bit accumulator adds the selected frequency word each cycle.
// - Top 12 accumulator bits plus offset address the sine table.
`timescale 1ns/1ps
module dtw_tuning_port #(
    parameter int FREQ_W = dtw_pkg::FREQ_W,
    parameter int PHASE_W = dtw_pkg::PHASE_W
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [15:0] host_data_bus_i,
    input wire logic [2:0] reg_select_i,
    input wire logic write_n_i,
    input wire logic tuning_word_sel_i,
    input wire logic offset_sel_bit0_i,
    input wire logic offset_sel_bit1_i,
    input wire logic sleep_n_i,
    input wire logic acc_reset_n_i,
    output logic [31:0] phase_acc_o,
    output logic [11:0] lut_addr_o,
    output logic out_enable_o
);
    // Write capture group
    logic write_n_q;
    logic write_n_d;
    logic pend_q;
    logic pend_d;
    dtw_pkg::dtw_write_s hold_q;
    dtw_pkg::dtw_write_s hold_d;

    always_comb
    begin
        write_n_d = write_n_i;
        pend_d = 1'b0;
        hold_d = hold_q;
        if (!write_n_q && write_n_i)
        begin
            hold_d.sel = reg_select_i;
            hold_d.data = host_data_bus_i;
            pend_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            write_n_q <= 1'b1;
            pend_q <= 1'b0;
            hold_q <= '0;
        end
        else
        begin
            write_n_q <= write_n_d;
            pend_q <= pend_d;
            hold_q <= hold_d;
        end
    end

    // Tuning register group
    localparam int N_F = dtw_pkg::N_FREQ;
    localparam int N_P = dtw_pkg::N_PHASE;
    localparam int HALF_W = dtw_pkg::DATA_W;
    logic [N_F-1:0][FREQ_W-1:0] freq_q;
    logic [N_P-1:0][PHASE_W-1:0] phase_q;
    logic [(2*N_F)-1:0] half_we;
    logic [N_P-1:0] phase_we;

    // One load strobe per destination; commit waits one edge after capture and loads one 16-bit half of a frequency word at a time
    always_comb
    begin
        half_we = '0;
        phase_we = '0;
        if (pend_q)
        begin
            case (hold_q.sel)
                dtw_pkg::SEL_FREQ0_LO,
                dtw_pkg::SEL_FREQ0_HI,
                dtw_pkg::SEL_FREQ1_LO,
                dtw_pkg::SEL_FREQ1_HI:
                begin
                    half_we[hold_q.sel[1:0]] = 1'b1;
                end
                default:
                begin
                    phase_we[hold_q.sel[1:0]] = 1'b1;
                end
            endcase
        end
    end

    // Halves load independently, so between the two writes a word mixes old and new halves
    for (genvar g = 0; g < N_F; g++)
    begin : g_freq
        logic [FREQ_W-1:0] word_q;
        logic [FREQ_W-1:0] word_d;

        always_comb
        begin
            word_d = word_q;
            if (half_we[2 * g])
            begin
                word_d[dtw_pkg::LO_HALF_LSB +: HALF_W] = hold_q.data;
            end
            if (half_we[(2 * g) + 1])
            begin
                word_d[dtw_pkg::HI_HALF_LSB +: HALF_W] = hold_q.data;
            end
        end

        always_ff @(posedge sys_clk_i)
        begin
            if (!resetn_i)
            begin
                word_q <= dtw_pkg::FREQ_RST;
            end
            else
            begin
                word_q <= word_d;
            end
        end

        assign freq_q[g] = word_q;
    end : g_freq

    for (genvar g = 0; g < N_P; g++)
    begin : g_phase
        logic [PHASE_W-1:0] offs_q;
        logic [PHASE_W-1:0] offs_d;

        always_comb
        begin
            offs_d = offs_q;
            if (phase_we[g])
            begin
                // Top nibble of the bus is don't-care for offsets
                offs_d = hold_q.data[dtw_pkg::PHASE_MSB:0];
            end
        end

        always_ff @(posedge sys_clk_i)
        begin
            if (!resetn_i)
            begin
                offs_q <= dtw_pkg::PHASE_RST;
            end
            else
            begin
                offs_q <= offs_d;
            end
        end

        assign phase_q[g] = offs_q;
    end : g_phase

    // Select sampling and accumulator group
    logic fsel_q;
    logic fsel_d;
    logic [1:0] psel_q;
    logic [1:0] psel_d;
    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic [11:0] addr_q;
    logic [11:0] addr_d;
    logic oen_q;
    logic oen_d;

    always_comb
    begin
        fsel_d = tuning_word_sel_i;
        psel_d = {offset_sel_bit1_i, offset_sel_bit0_i};
        oen_d = sleep_n_i;
        acc_d = acc_q;
        addr_d = addr_q;
        if (!acc_reset_n_i)
        begin
            acc_d = dtw_pkg::ACC_RST;
        end
        else if (sleep_n_i)
        begin
            // Plain 32-bit add drops the carry, giving a continuous wrap
            acc_d = acc_q + freq_q[fsel_q];
        end
        if (sleep_n_i)
        begin
            addr_d = acc_q[31:dtw_pkg::LUT_LSB] + phase_q[psel_q];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            fsel_q <= 1'b0;
            psel_q <= 2'h0;
            acc_q <= dtw_pkg::ACC_RST;
            addr_q <= dtw_pkg::ADDR_RST;
            oen_q <= 1'b0;
        end
        else
        begin
            fsel_q <= fsel_d;
            psel_q <= psel_d;
            acc_q <= acc_d;
            addr_q <= addr_d;
            oen_q <= oen_d;
        end
    end

    assign phase_acc_o = acc_q;
    assign lut_addr_o = addr_q;
    assign out_enable_o = oen_q;
endmodule : dtw_tuning_port

// File: bench/dtw_host.sv
// Host model driving the parallel write strobe
`timescale 1ns/1ps
module dtw_host (
    input logic sys_clk_i,
    output logic [15:0] data_o,
    output logic [2:0] sel_o,
    output logic write_n_o = 1'b1
);
    // Strobe moves just after a clock edge, never on it
    task automatic wr(input logic [2:0] s, input logic [15:0] d);
        @(posedge sys_clk_i);
        write_n_o <= 1'b0;
        sel_o <= s;
        data_o <= d;
        repeat (2) @(posedge sys_clk_i);
        write_n_o <= 1'b1;
        @(posedge sys_clk_i);
        data_o <= ~d;
    endtask : wr
endmodule : dtw_host

// File: bench/dtw_tuning_port_chk.sv
// Assertions on the tuning write port
`timescale 1ns/1ps
module dtw_tuning_port_chk (
    input logic sys_clk_i,
    input logic resetn_i,
    input logic write_n_i,
    input logic tuning_word_sel_i,
    input logic offset_sel_bit0_i,
    input logic offset_sel_bit1_i,
    input logic sleep_n_i,
    input logic acc_reset_n_i,
    input logic [31:0] phase_acc_o,
    input logic [11:0] lut_addr_o,
    input logic out_enable_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // Awake, write strobe high, selects steady
    sequence s_calm(r);
        sleep_n_i && write_n_i && r && $stable(tuning_word_sel_i) && $stable({offset_sel_bit1_i, offset_sel_bit0_i});
    endsequence
    sequence s_step;
        (phase_acc_o - $past(phase_acc_o)) == ($past(phase_acc_o) - $past(phase_acc_o, 2));
    endsequence
    property p_clr; !acc_reset_n_i |=> phase_acc_o == 32'h0; endproperty
    a_clr: assert property (p_clr) else $error("acc not cleared");
    property p_hold; !sleep_n_i && acc_reset_n_i |=> $stable(phase_acc_o); endproperty
    a_hold: assert property (p_hold) else $error("acc moved in sleep");
    property p_lhold; !sleep_n_i && acc_reset_n_i && $past(acc_reset_n_i) |=> $stable(lut_addr_o); endproperty
    a_lhold: assert property (p_lhold) else $error("lut moved in sleep");
    property p_oe; $past(resetn_i) |-> out_enable_o == $past(sleep_n_i); endproperty
    a_oe: assert property (p_oe) else $error("enable wrong");
    property p_step; s_calm(acc_reset_n_i)[*4] |=> s_step; endproperty
    a_step: assert property (p_step) else $error("step not steady");
    property p_lut;
        s_calm(acc_reset_n_i)[*4] |=>
            (lut_addr_o - $past(phase_acc_o[31:20])) == ($past(lut_addr_o) - $past(phase_acc_o[31:20], 2));
    endproperty
    a_lut: assert property (p_lut) else $error("lut offset drift");
    property p_lzero; s_calm(!acc_reset_n_i)[*4] |=> $stable(lut_addr_o); endproperty
    a_lzero: assert property (p_lzero) else $error("lut moved in clear");
    property p_cap;
        (sleep_n_i && acc_reset_n_i && !write_n_i && $stable(tuning_word_sel_i))[*2] ##1 s_calm(acc_reset_n_i)
            |=> s_step;
    endproperty
    a_cap: assert property (p_cap) else $error("write landed early");
endmodule : dtw_tuning_port_chk
bind dtw_tuning_port dtw_tuning_port_chk i_dtw_tuning_port_chk (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .write_n_i(write_n_i),
    .tuning_word_sel_i(tuning_word_sel_i),
    .offset_sel_bit0_i(offset_sel_bit0_i),
    .offset_sel_bit1_i(offset_sel_bit1_i),
    .sleep_n_i(sleep_n_i),
    .acc_reset_n_i(acc_reset_n_i),
    .phase_acc_o(phase_acc_o),
    .lut_addr_o(lut_addr_o),
    .out_enable_o(out_enable_o)
);

// File: bench/dtw_tuning_port_tb.sv
// Self-checking bench for the tuning write port
`timescale 1ns/1ps
module dtw_tuning_port_tb;
    logic sys_clk_i = 1'b0, resetn_i = 1'b0, tuning_word_sel_i = 1'b0, sleep_n_i = 1'b1, acc_reset_n_i = 1'b0;
    logic offset_sel_bit0_i = 1'b0, offset_sel_bit1_i = 1'b0, write_n_i, out_enable_o;
    logic [15:0] host_data_bus_i;
    logic [2:0] reg_select_i;
    logic [31:0] phase_acc_o, a;
    logic [11:0] lut_addr_o;
    logic [31:0] fw [2] = '{32'h0010_8001, 32'h0030_0002};
    int failures = 0, num_checks = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    dtw_tuning_port i_dtw_tuning_port (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .host_data_bus_i(host_data_bus_i),
        .reg_select_i(reg_select_i),
        .write_n_i(write_n_i),
        .tuning_word_sel_i(tuning_word_sel_i),
        .offset_sel_bit0_i(offset_sel_bit0_i),
        .offset_sel_bit1_i(offset_sel_bit1_i),
        .sleep_n_i(sleep_n_i),
        .acc_reset_n_i(acc_reset_n_i),
        .phase_acc_o(phase_acc_o),
        .lut_addr_o(lut_addr_o),
        .out_enable_o(out_enable_o)
    );
    dtw_host i_dtw_host (.sys_clk_i(sys_clk_i), .data_o(host_data_bus_i), .sel_o(reg_select_i), .write_n_o(write_n_i));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask : tick
    initial
    begin
        tick(3);
        chk("enable", out_enable_o, 32'h0);
        @(posedge sys_clk_i) resetn_i <= 1'b1;
        tick(3);
        @(posedge sys_clk_i) acc_reset_n_i <= 1'b1;
        tick(4);
        chk("acc", phase_acc_o, 32'h0);
        chk("lut", lut_addr_o, 32'h0);
        // First half write: old step for one edge after capture, new step from the next
        i_dtw_host.wr(3'h0, fw[0][15:0]);
        tick(0);
        a = phase_acc_o;
        tick(1);
        chk("land", phase_acc_o, a);
        tick(1);
        chk("land", phase_acc_o, a + 32'(fw[0][15:0]));
        for (int k = 1; k < 4; k++)
            i_dtw_host.wr(3'(k), fw[k / 2][(k % 2) * 16 +: 16]);
        // Top nibble is junk that must not reach the offset
        for (int k = 0; k < 4; k++)
            i_dtw_host.wr(3'(k + 4), 16'hf000 | 16'((k + 1) * 256));
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sys_clk_i);
            tuning_word_sel_i <= i[2];
            {offset_sel_bit1_i, offset_sel_bit0_i} <= i[1:0];
            tick(2);
            a = phase_acc_o;
            tick(1);
            chk("step", phase_acc_o - a, fw[i[2]]);
            chk("lut", lut_addr_o, 32'(12'(a[31:20] + (i % 4 + 1) * 256)));
        end
        @(posedge sys_clk_i) sleep_n_i <= 1'b0;
        tick(2);
        a = phase_acc_o;
        chk("enable", out_enable_o, 32'h0);
        tick(3);
        chk("sleep", phase_acc_o, a);
        @(posedge sys_clk_i);
        sleep_n_i <= 1'b1;
        acc_reset_n_i <= 1'b0;
        tick(2);
        chk("clear", phase_acc_o, 32'h0);
        chk("enable", out_enable_o, 32'h1);
        end_sim();
    end
    initial
    begin
        repeat (400) @(posedge sys_clk_i);
        failures++;
        end_sim();
    end
endmodule : dtw_tuning_port_tb
